// ### inc/nv_host_pkg.sv
// constants and types shared by the nonvolatile sram host controller
package nv_host_pkg;

  // ---------------------------------------------------------------
  // bus widths and clock
  // ---------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CLOCK_PERIOD_NS = 20;

  // ---------------------------------------------------------------
  // pin timing, in ns, and derived cycle counts (least times round up)
  // ---------------------------------------------------------------
  localparam int ADDRESS_ACCESS_DELAY_NS = 45;
  localparam int WRITE_PULSE_NS = 45;
  localparam int ACCESS_CYCLES = (ADDRESS_ACCESS_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int WRITE_CYCLES = (WRITE_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // ---------------------------------------------------------------
  // busy durations, in us, and derived cycle counts
  // ---------------------------------------------------------------
  localparam int SAVE_DURATION_US = 10000;
  localparam int RESTORE_DURATION_US = 20;
  localparam int POWERUP_RESTORE_DURATION_US = 20000;
  localparam int SAVE_CYCLES = (SAVE_DURATION_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int RESTORE_CYCLES = (RESTORE_DURATION_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int POWERUP_CYCLES =
    (POWERUP_RESTORE_DURATION_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // ---------------------------------------------------------------
  // software save / restore address sequence (low 14 bits)
  // ---------------------------------------------------------------
  localparam int SEQ_LEN = 6;
  localparam logic [13:0] SEQ_ADDR_0 = 14'h0E38;
  localparam logic [13:0] SEQ_ADDR_1 = 14'h31C7;
  localparam logic [13:0] SEQ_ADDR_2 = 14'h03E0;
  localparam logic [13:0] SEQ_ADDR_3 = 14'h3C1F;
  localparam logic [13:0] SEQ_ADDR_4 = 14'h303F;
  localparam logic [13:0] SEQ_SAVE_ADDR = 14'h0FC0;
  localparam logic [13:0] SEQ_RESTORE_ADDR = 14'h0C63;

  // ---------------------------------------------------------------
  // host command codes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_WRITE = 2'h1,
    OP_SAVE = 2'h2,
    OP_RESTORE = 2'h3
  } op_t;

endpackage : nv_host_pkg

// ### inc/bus_cycle_if.sv
// one pin-level bus cycle request and its answer
interface bus_cycle_if;
  import nv_host_pkg::*;
  logic req;
  logic wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic done;
  modport master (output req, wr, addr, wdata, input rdata, done);
  modport slave (input req, wr, addr, wdata, output rdata, done);
endinterface : bus_cycle_if

// ### design/pin_cycle_engine.sv
// pin cycle engine: runs one sram read or write cycle on the pins
module pin_cycle_engine (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // cycle request
  bus_cycle_if.slave cyc,
  // sram pins
  output logic chip_sel_n,
  output logic write_en_n,
  output logic out_en_n,
  output logic [nv_host_pkg::ADDR_W-1:0] byte_address,
  output logic [nv_host_pkg::DATA_W-1:0] data_out,
  output logic data_oe_n,
  input wire logic [nv_host_pkg::DATA_W-1:0] data_in
);
  import nv_host_pkg::*;

  typedef enum logic [3:0] {
    E_IDLE = 4'h1,
    E_SETUP = 4'h2,
    E_STROBE = 4'h4,
    E_RECOVER = 4'h8
  } eng_t;

  eng_t st_r;
  logic wr_r;
  logic [3:0] cnt_r;
  logic [DATA_W-1:0] rdata_r;
  logic done_r;

  assign cyc.rdata = rdata_r;
  assign cyc.done = done_r;

  // ---------------------------------------------------------------
  // cycle sequencer
  // ---------------------------------------------------------------
  // address first, strobes one cycle later, address held at least two cycles past
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      st_r <= E_IDLE;
      wr_r <= 1'b0;
      cnt_r <= 4'h0;
      done_r <= 1'b0;
      byte_address <= '0;
      data_out <= '0;
    end else begin
      done_r <= 1'b0;
      case (st_r)
        E_IDLE: begin
          if (cyc.req) begin
            byte_address <= cyc.addr; // [RULE_04]
            data_out <= cyc.wdata;
            wr_r <= cyc.wr;
            st_r <= E_SETUP;
          end
        end
        E_SETUP: begin
          cnt_r <= wr_r ? 4'(WRITE_CYCLES - 1) : 4'(ACCESS_CYCLES - 1);
          st_r <= E_STROBE;
        end
        E_STROBE: begin
          if (cnt_r == 4'h0) begin
            st_r <= E_RECOVER;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        E_RECOVER: begin
          done_r <= 1'b1;
          st_r <= E_IDLE;
        end
        default: st_r <= E_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pin strobes
  // ---------------------------------------------------------------
  // chip select frames the cycle; reads end on chip select rising
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      chip_sel_n <= 1'b1;
      write_en_n <= 1'b1;
      out_en_n <= 1'b1;
      data_oe_n <= 1'b1;
    end else begin
      chip_sel_n <= !(st_r == E_SETUP || (st_r == E_STROBE && cnt_r != 4'h0));
      // write enable stays high on every read, sequence reads included
      write_en_n <= !(wr_r && (st_r == E_SETUP || (st_r == E_STROBE && cnt_r != 4'h0))); // [RULE_21]
      // output enable only on reads, never during a write
      out_en_n <= !(!wr_r && (st_r == E_SETUP || (st_r == E_STROBE && cnt_r != 4'h0))); // [RULE_05]
      // data driven through the write and one hold cycle after it
      data_oe_n <= !(wr_r && (st_r == E_SETUP || st_r == E_STROBE));
    end
  end

  // read data captured just before chip select rises
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rdata_r <= '0;
    end else if (st_r == E_STROBE && cnt_r == 4'h0 && !wr_r) begin
      rdata_r <= data_in;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_write_addr_stable: assert property (@(posedge clock) disable iff (!reset_n)
    (!write_en_n || $past(!write_en_n)) |-> $stable(byte_address)) // [RULE_04]
    else $error("address moved during write cycle");
  a_write_oe_high: assert property (@(posedge clock) disable iff (!reset_n)
    !write_en_n |-> out_en_n && !data_oe_n) // [RULE_05]
    else $error("output enable low or data undriven during write");
  a_write_pulse_len: assert property (@(posedge clock) disable iff (!reset_n)
    $fell(write_en_n) |-> !write_en_n [*3] ##1 write_en_n) // [RULE_03]
    else $error("write pulse length wrong");
  a_read_we_high: assert property (@(posedge clock) disable iff (!reset_n)
    !out_en_n |-> write_en_n && data_oe_n && !chip_sel_n) // [RULE_21]
    else $error("write enable low or bus driven during read");
endmodule : pin_cycle_engine

// ### design/nv_sram_host.sv
// host controller for a nonvolatile sram: reads, writes, save, restore
//
// Summary of operation
// RULE_01 - device reads when select, output enable low
// RULE_02 - read data follows address until deselect
// RULE_03 - device writes when select and write low
// RULE_04 - host holds address stable through write
// RULE_05 - host keeps output enable high writing
// RULE_06 - device turns drivers off after write
// RULE_07 - power-loss save skipped without prior write
// RULE_08 - software save always runs
// RULE_09 - power-up restore latched, runs above threshold
// RULE_10 - host must not write during power-up restore
// RULE_11 - six reads ending 0x0FC0 start save
// RULE_12 - same five reads then 0x0C63 restore
// RULE_13 - intervening access aborts the sequence
// RULE_14 - only reads count; output enable optional
// RULE_15 - save erases then programs nonvolatile cells
// RULE_16 - bus disabled for the save duration
// RULE_17 - restore clears then copies into sram
// RULE_18 - restore keeps nonvolatile data, unlimited repeats
// RULE_19 - low capacitor voltage blocks saves, writes; the model still runs a power-loss save when low_cap is high
// RULE_20 - sequence match uses low 14 address bits
// RULE_21 - write enable high for all six reads
// RULE_22 - tracker steps on chip select rising
// RULE_23 - durations are parameters; busy holds bus
// RULE_24 - write flag set by write, cleared by transfer
module nv_sram_host #(
  parameter int unsigned SAVE_WAIT = nv_host_pkg::SAVE_CYCLES,
  parameter int unsigned RESTORE_WAIT = nv_host_pkg::RESTORE_CYCLES,
  parameter int unsigned POWERUP_WAIT = nv_host_pkg::POWERUP_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // user command port
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic [nv_host_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [nv_host_pkg::DATA_W-1:0] cmd_wdata,
  output logic cmd_ready,
  output logic cmd_done,
  output logic [nv_host_pkg::DATA_W-1:0] rd_data,
  output logic nv_busy,
  // sram pins
  output logic chip_sel_n,
  output logic write_en_n,
  output logic out_en_n,
  output logic [nv_host_pkg::ADDR_W-1:0] byte_address,
  output logic [nv_host_pkg::DATA_W-1:0] data_lines_out,
  output logic data_lines_oe_n,
  input wire logic [nv_host_pkg::DATA_W-1:0] data_lines_in
);
  import nv_host_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    S_POWERUP = 5'h01,
    S_IDLE = 5'h02,
    S_ACCESS = 5'h04,
    S_SEQ = 5'h08,
    S_BUSY = 5'h10
  } host_state_t;

  host_state_t st_r;
  logic [31:0] timer_r;
  logic [2:0] step_r;
  logic save_r;
  logic req_r;
  logic wr_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [ADDR_W-1:0] seq_addr_nxt;

  bus_cycle_if cyc ();

  assign cyc.req = req_r;
  assign cyc.wr = wr_r;
  assign cyc.addr = addr_r;
  assign cyc.wdata = wdata_r;

  // ---------------------------------------------------------------
  // sequence address table
  // ---------------------------------------------------------------
  // next address of the six-read sequence; top address bit sent as zero
  always_comb begin
    seq_addr_nxt = '0;
    case (step_r)
      3'h0: seq_addr_nxt = {1'b0, SEQ_ADDR_1}; // [RULE_20]
      3'h1: seq_addr_nxt = {1'b0, SEQ_ADDR_2};
      3'h2: seq_addr_nxt = {1'b0, SEQ_ADDR_3};
      3'h3: seq_addr_nxt = {1'b0, SEQ_ADDR_4};
      3'h4: seq_addr_nxt = {1'b0, save_r ? SEQ_SAVE_ADDR : SEQ_RESTORE_ADDR}; // [RULE_11] [RULE_12]
      default: seq_addr_nxt = {1'b0, SEQ_ADDR_0};
    endcase
  end

  // ---------------------------------------------------------------
  // command state machine
  // ---------------------------------------------------------------
  // after reset the device runs its own restore; no cycle until it ends
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      st_r <= S_POWERUP;
      timer_r <= 32'h0000_0000;
      step_r <= 3'h0;
      save_r <= 1'b0;
      req_r <= 1'b0;
      wr_r <= 1'b0;
      addr_r <= '0;
      wdata_r <= '0;
    end else begin
      req_r <= 1'b0;
      case (st_r)
        S_POWERUP: begin
          if (timer_r == 32'(POWERUP_WAIT - 1)) begin // [RULE_10]
            st_r <= S_IDLE;
          end else begin
            timer_r <= timer_r + 32'h1;
          end
        end
        S_IDLE: begin
          if (cmd_valid) begin
            if (op_t'(cmd_op) == OP_READ || op_t'(cmd_op) == OP_WRITE) begin
              wr_r <= op_t'(cmd_op) == OP_WRITE;
              addr_r <= cmd_addr;
              wdata_r <= cmd_wdata;
              req_r <= 1'b1;
              st_r <= S_ACCESS;
            end else begin
              // sequence reads only; nothing may come between them
              save_r <= op_t'(cmd_op) == OP_SAVE;
              wr_r <= 1'b0; // [RULE_21]
              addr_r <= {1'b0, SEQ_ADDR_0};
              step_r <= 3'h0;
              req_r <= 1'b1;
              st_r <= S_SEQ; // [RULE_13]
            end
          end
        end
        S_ACCESS: begin
          if (cyc.done) begin
            st_r <= S_IDLE;
          end
        end
        S_SEQ: begin
          if (cyc.done) begin
            if (step_r == 3'(SEQ_LEN - 1)) begin
              // sixth read launched the transfer; wait out its duration
              timer_r <= 32'h0000_0000;
              st_r <= S_BUSY; // [RULE_16]
            end else begin
              addr_r <= seq_addr_nxt;
              step_r <= step_r + 3'h1;
              req_r <= 1'b1;
            end
          end
        end
        S_BUSY: begin
          if (timer_r == (save_r ? 32'(SAVE_WAIT - 1) : 32'(RESTORE_WAIT - 1))) begin // [RULE_23]
            st_r <= S_IDLE;
          end else begin
            timer_r <= timer_r + 32'h1;
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // user answers
  // ---------------------------------------------------------------
  // ready in idle, done pulse at the end of each command
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cmd_ready <= 1'b0;
      cmd_done <= 1'b0;
      nv_busy <= 1'b1;
      rd_data <= '0;
    end else begin
      cmd_ready <= (st_r == S_IDLE && !cmd_valid) || (st_r == S_ACCESS && cyc.done) ||
        (st_r == S_BUSY && timer_r == (save_r ? 32'(SAVE_WAIT - 1) : 32'(RESTORE_WAIT - 1))) ||
        (st_r == S_POWERUP && timer_r == 32'(POWERUP_WAIT - 1));
      cmd_done <= (st_r == S_ACCESS && cyc.done) ||
        (st_r == S_BUSY && timer_r == (save_r ? 32'(SAVE_WAIT - 1) : 32'(RESTORE_WAIT - 1)));
      nv_busy <= (st_r == S_POWERUP && timer_r != 32'(POWERUP_WAIT - 1)) ||
        (st_r == S_SEQ && cyc.done && step_r == 3'(SEQ_LEN - 1)) ||
        (st_r == S_BUSY && timer_r != (save_r ? 32'(SAVE_WAIT - 1) : 32'(RESTORE_WAIT - 1)));
      if (st_r == S_ACCESS && cyc.done && !wr_r) begin
        rd_data <= cyc.rdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // pin cycle engine
  // ---------------------------------------------------------------
  pin_cycle_engine u_engine (
    .clock (clock),
    .reset_n (reset_n),
    .cyc (cyc.slave),
    .chip_sel_n (chip_sel_n),
    .write_en_n (write_en_n),
    .out_en_n (out_en_n),
    .byte_address (byte_address),
    .data_out (data_lines_out),
    .data_oe_n (data_lines_oe_n),
    .data_in (data_lines_in)
  );

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_powerup_no_access: assert property (@(posedge clock) disable iff (!reset_n)
    st_r == S_POWERUP |-> chip_sel_n && write_en_n && !req_r) // [RULE_10]
    else $error("bus cycle during power-up restore");
  a_seq_save_last: assert property (@(posedge clock) disable iff (!reset_n)
    (req_r && st_r == S_SEQ && step_r == 3'h5 && save_r) |->
    addr_r == {1'b0, SEQ_SAVE_ADDR} ##1 addr_r == {1'b0, SEQ_SAVE_ADDR}) // [RULE_11]
    else $error("save sequence last address wrong");
  a_seq_restore_last: assert property (@(posedge clock) disable iff (!reset_n)
    (req_r && st_r == S_SEQ && step_r == 3'h5 && !save_r) |->
    addr_r == {1'b0, SEQ_RESTORE_ADDR}) // [RULE_12]
    else $error("restore sequence last address wrong");
  a_seq_first_addr: assert property (@(posedge clock) disable iff (!reset_n)
    (req_r && st_r == S_SEQ && step_r == 3'h0) |-> addr_r == {1'b0, SEQ_ADDR_0}) // [RULE_11]
    else $error("sequence does not open at first address");
  a_seq_we_high: assert property (@(posedge clock) disable iff (!reset_n)
    st_r == S_SEQ |-> write_en_n && data_lines_oe_n) // [RULE_21]
    else $error("write enable low inside sequence");
  a_busy_no_cycle: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(st_r == S_BUSY) |-> (chip_sel_n && nv_busy) [*3]) // [RULE_23]
    else $error("bus used while transfer busy");

  c_save_done: cover property (@(posedge clock) disable iff (!reset_n)
    st_r == S_BUSY && save_r ##1 st_r == S_IDLE);
  c_restore_done: cover property (@(posedge clock) disable iff (!reset_n)
    st_r == S_BUSY && !save_r ##1 st_r == S_IDLE);
  c_write_done: cover property (@(posedge clock) disable iff (!reset_n)
    st_r == S_ACCESS && wr_r && cyc.done);
  c_read_done: cover property (@(posedge clock) disable iff (!reset_n)
    st_r == S_ACCESS && !wr_r && cyc.done);
endmodule : nv_sram_host

// ### verification/nvsram_model.sv
// behavioural model of the nonvolatile sram on the far side of the host
module nvsram_model #(
  parameter int SAVE_T = 40,
  parameter int RESTORE_T = 20,
  parameter int POWERUP_T = 30
) (
  // clock and power events
  input wire logic clock,
  input wire logic reset_n,
  input wire logic power_loss,
  input wire logic low_cap,
  // sram pins
  input wire logic chip_sel_n,
  input wire logic write_en_n,
  input wire logic out_en_n,
  input wire logic [nv_host_pkg::ADDR_W-1:0] byte_address,
  input wire logic [nv_host_pkg::DATA_W-1:0] host_dq,
  input wire logic host_oe_n,
  output logic [nv_host_pkg::DATA_W-1:0] dq_bus
);
  timeunit 1ns;
  timeprecision 100ps;
  import nv_host_pkg::*;
  logic [7:0] mem [32768];
  logic [7:0] nv [32768];
  logic [13:0] seq [5];
  logic [7:0] last_r;
  logic [14:0] cyc_addr;
  logic in_cyc, cyc_wr, wflag, pl_r, pend_save, pend_restore, drive;
  int busy_cnt, step, saves_run, restores_run, pin_faults;

  // both arrays start cleared
  initial begin
    seq = '{SEQ_ADDR_0, SEQ_ADDR_1, SEQ_ADDR_2, SEQ_ADDR_3, SEQ_ADDR_4};
    foreach (mem[i]) begin
      mem[i] = 8'h00;
      nv[i] = 8'h00;
    end
    {in_cyc, cyc_wr, wflag, pl_r, pend_save, pend_restore, last_r} = '0;
    {busy_cnt, step, saves_run, restores_run, pin_faults} = '0;
  end

  // drive only a selected read while idle; released lines show the inverse
  assign drive = !chip_sel_n && !out_en_n && write_en_n && busy_cnt == 0;
  assign dq_bus = !host_oe_n ? host_dq : drive ? mem[byte_address] : ~last_r;

  // cycles, sequence tracker and busy periods
  always @(posedge clock) begin
    last_r <= dq_bus;
    pl_r <= power_loss;
    if (!reset_n) begin
      busy_cnt <= POWERUP_T;
      pend_restore <= 1'b1;
      step <= 0;
      {in_cyc, cyc_wr} <= '0;
    end else if (busy_cnt > 0) begin
      busy_cnt <= busy_cnt - 1;
      if (!chip_sel_n && !write_en_n) pin_faults <= pin_faults + 1;
      if (busy_cnt == 1) begin
        foreach (mem[i]) begin
          if (pend_save) begin
            nv[i] = 8'hFF;
            nv[i] = mem[i];
          end else begin
            mem[i] = 8'h00;
            mem[i] = nv[i];
          end
        end
        {pend_save, pend_restore, wflag} <= '0;
      end
    end else if (power_loss && !pl_r && wflag) begin
      pend_save <= 1'b1;
      busy_cnt <= SAVE_T;
      saves_run <= saves_run + 1;
    end else if (!chip_sel_n) begin
      in_cyc <= 1'b1;
      cyc_wr <= cyc_wr | !write_en_n;
      if (!in_cyc) cyc_addr <= byte_address;
      if (!write_en_n) begin
        if (!out_en_n || (in_cyc && byte_address != cyc_addr)) begin
          pin_faults <= pin_faults + 1;
        end
        if (!low_cap) begin
          mem[byte_address] = dq_bus;
          wflag <= 1'b1;
        end
      end
    end else if (in_cyc) begin
      // chip select rising ends a cycle
      {in_cyc, cyc_wr} <= '0;
      if (cyc_wr || step == 5) step <= 0;
      if (!cyc_wr && step == 5 && !low_cap && cyc_addr[13:0] == SEQ_SAVE_ADDR) begin
        pend_save <= 1'b1;
        busy_cnt <= SAVE_T;
        saves_run <= saves_run + 1;
      end
      if (!cyc_wr && step == 5 && cyc_addr[13:0] == SEQ_RESTORE_ADDR) begin
        pend_restore <= 1'b1;
        busy_cnt <= RESTORE_T;
        restores_run <= restores_run + 1;
      end
      if (!cyc_wr && step < 5) begin
        step <= (cyc_addr[13:0] == seq[step]) ? step + 1 : int'(cyc_addr[13:0] == seq[0]);
      end
    end
  end
endmodule : nvsram_model

// ### verification/nv_sram_host_tb_top.sv
// self-checking testbench for the nonvolatile sram host controller
module nv_sram_host_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import nv_host_pkg::*;
  localparam int SAVE_T = 40;
  localparam int RESTORE_T = 20;
  localparam int POWERUP_T = 30;
  logic clock, reset_n, cmd_valid, cmd_ready, cmd_done, nv_busy, power_loss, low_cap;
  logic chip_sel_n, write_en_n, out_en_n, data_lines_oe_n, poke_en;
  logic [1:0] cmd_op;
  logic [ADDR_W-1:0] cmd_addr, byte_address;
  logic [DATA_W-1:0] cmd_wdata, rd_data, data_lines_out, data_lines_in;
  int err_total, checks_done, n, busy_seen;

  nv_sram_host #(.SAVE_WAIT(SAVE_T), .RESTORE_WAIT(RESTORE_T), .POWERUP_WAIT(POWERUP_T)) DUT (
    .clock(clock), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
    .rd_data(rd_data), .nv_busy(nv_busy), .chip_sel_n(chip_sel_n), .write_en_n(write_en_n),
    .out_en_n(out_en_n), .byte_address(byte_address), .data_lines_out(data_lines_out),
    .data_lines_oe_n(data_lines_oe_n), .data_lines_in(data_lines_in));

  nvsram_model #(.SAVE_T(SAVE_T), .RESTORE_T(RESTORE_T), .POWERUP_T(POWERUP_T)) dev (
    .clock(clock), .reset_n(reset_n), .power_loss(power_loss), .low_cap(low_cap),
    .chip_sel_n(chip_sel_n), .write_en_n(write_en_n), .out_en_n(out_en_n),
    .byte_address(byte_address), .host_dq(data_lines_out), .host_oe_n(data_lines_oe_n),
    .dq_bus(data_lines_in));

  // 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one command, waiting for ready then done; optional poke while busy
  task automatic cmd(input logic [1:0] op, input logic [14:0] a, input logic [7:0] d);
    n = 0;
    while (cmd_ready !== 1'b1 && n < 5000) begin
      @(posedge clock);
      #1;
      n++;
    end
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_valid = 1'b1;
    @(posedge clock);
    #1;
    cmd_valid = 1'b0;
    n = 0;
    busy_seen = 0;
    while (cmd_done !== 1'b1 && n < 5000) begin
      @(posedge clock);
      #1;
      n++;
      if (nv_busy === 1'b1) busy_seen++;
      if (poke_en && n == 55) begin
        check(cmd_ready, 0);
        cmd_op = OP_WRITE;
        cmd_valid = 1'b1;
      end
      if (n == 56) cmd_valid = 1'b0;
    end
    if (n >= 5000) err_total++;
  endtask : cmd

  // read and compare
  task automatic rd(input logic [14:0] a, input logic [7:0] exp);
    cmd(OP_READ, a, 8'h00);
    check(rd_data, exp);
  endtask : rd

  // power-loss pulse, then let a save finish
  task automatic pulse_loss;
    power_loss = 1'b1;
    @(posedge clock);
    #1;
    power_loss = 1'b0;
    repeat (SAVE_T + 3) @(posedge clock);
    #1;
  endtask : pulse_loss

  // reset state and power-up wait
  task automatic t_powerup;
    check(nv_busy, 1);
    check(cmd_ready, 0);
    reset_n = 1'b1;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 1000) begin
      @(posedge clock);
      #1;
      n++;
    end
    check(n >= POWERUP_T, 1);
  endtask : t_powerup

  // back-to-back writes and reads at both end addresses and one middle address
  task automatic t_rw;
    cmd(OP_WRITE, 15'h0000, 8'h5A);
    cmd(OP_WRITE, 15'h7FFF, 8'hC3);
    cmd(OP_WRITE, 15'h1234, 8'hA5);
    rd(15'h7FFF, 8'hC3);
    check(n, 7);
    rd(15'h0000, 8'h5A);
    rd(15'h1234, 8'hA5);
  endtask : t_rw

  // software save, a refused write while busy, and a save with no write
  task automatic t_save;
    int k;
    cmd(OP_WRITE, 15'h0100, 8'h3C);
    k = dev.saves_run;
    poke_en = 1'b1;
    cmd(OP_SAVE, 15'h0100, 8'hEE);
    poke_en = 1'b0;
    check(dev.saves_run, k + 1);
    check(dev.nv[15'h0100], 8'h3C);
    check(busy_seen >= SAVE_T, 1);
    rd(15'h0100, 8'h3C);
    cmd(OP_SAVE, 15'h0000, 8'h00);
    check(dev.saves_run, k + 2);
  endtask : t_save

  // software restore, repeated
  task automatic t_restore;
    int k;
    k = dev.restores_run;
    cmd(OP_WRITE, 15'h0100, 8'h77);
    rd(15'h0100, 8'h77);
    cmd(OP_RESTORE, 15'h0000, 8'h00);
    rd(15'h0100, 8'h3C);
    cmd(OP_RESTORE, 15'h0000, 8'h00);
    rd(15'h0100, 8'h3C);
    check(dev.restores_run, k + 2);
    check(dev.nv[15'h0100], 8'h3C);
  endtask : t_restore

  // power-loss save skipped without a write, run after one
  task automatic t_autosave;
    int k;
    k = dev.saves_run;
    pulse_loss();
    check(dev.saves_run, k);
    cmd(OP_WRITE, 15'h0200, 8'h96);
    pulse_loss();
    check(dev.saves_run, k + 1);
    check(dev.nv[15'h0200], 8'h96);
  endtask : t_autosave

  // low storage voltage blocks writes and software saves
  task automatic t_lowcap;
    int k;
    k = dev.saves_run;
    low_cap = 1'b1;
    cmd(OP_WRITE, 15'h0300, 8'h11);
    rd(15'h0300, 8'h00);
    cmd(OP_SAVE, 15'h0000, 8'h00);
    check(dev.saves_run, k);
    low_cap = 1'b0;
    cmd(OP_WRITE, 15'h0300, 8'h22);
    rd(15'h0300, 8'h22);
  endtask : t_lowcap

  // counts and verdict
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  // main sequence
  initial begin
    {reset_n, cmd_valid, power_loss, low_cap, poke_en} = '0;
    cmd_op = OP_READ;
    cmd_addr = '0;
    cmd_wdata = '0;
    {err_total, checks_done} = '0;
    repeat (5) @(posedge clock);
    #1;
    t_powerup();
    t_rw();
    t_save();
    t_restore();
    t_autosave();
    t_lowcap();
    check(dev.pin_faults, 0);
    test_done();
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    test_done();
  end
endmodule : nv_sram_host_tb_top
